// File: core/mcc_regs.svh
`ifndef MCC_REGS_SVH
`define MCC_REGS_SVH
// register offsets on the plain port
`define MCC_ADDR_CTRL      4'h0
`define MCC_ADDR_TRIM      4'h1
`define MCC_ADDR_STATUS    4'h2
`define MCC_ADDR_FTRIM5    4'h3
`define MCC_ADDR_FTRIM3    4'h4
// reset values and control write mask
`define MCC_CTRL_RESET     8'h00
`define MCC_TRIM_RESET     8'hff
`define MCC_CTRL_WMASK     8'h03
// field positions
`define MCC_BIT_SLOW       0
`define MCC_BIT_CKOUT      1
`define MCC_BIT_LOCK       0
// nonvolatile trim locations and their mirrors
`define MCC_NV_TRIM5       16'h1000
`define MCC_NV_TRIM3       16'h1001
`define MCC_NV_TRIM5_MIR   16'hffde
`define MCC_NV_TRIM3_MIR   16'hffdf
`define MCC_NV_ERASED      8'hff
// slow mode divide and pll start-up
`define MCC_SLOW_DIV       32
`define MCC_STARTUP_NS     64000
`define MCC_CLK_NS         50
`endif

// File: core/mcc_pkg.sv
package mcc_pkg;
  // main clock source chosen by option byte
  typedef enum logic [1:0] {
    MCC_SRC_EXT,
    MCC_SRC_XTAL,
    MCC_SRC_RC,
    MCC_SRC_PB4
  } mcc_src_e;
  // pll start-up state
  typedef enum logic [1:0] {
    MCC_PLL_OFF,
    MCC_PLL_WAIT,
    MCC_PLL_LOCKED
  } mcc_pll_e;
endpackage

// File: core/mcc_clock_ctrl.sv
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "mcc_regs.svh"

// Overview of operation
// RULE1 - every reset loads the rc trim register with ff
// RULE2 - trim code zero is fastest rc frequency, ff is slowest
// RULE3 - software writes trim right after reset for one percent accuracy
// RULE4 - factory 5v and 3v trims held at 1000h, 1001h and mirrors
// RULE5 - factory trims erased when readout protection is cleared after set
// RULE6 - software may binary search trim codes starting from 80h
// RULE7 - two option bits enable pll and pick times four or eight
// RULE8 - pll off with rc on gives the plain 1 MHz rc clock
// RULE9 - rc and pll off takes oscillator clock from external input
// RULE10 - on each pll start, output clock withheld for start-up delay
// RULE11 - lock flag set once pll reaches operating frequency
// RULE12 - control register resets to zero, bits 7 to 2 kept zero
// RULE13 - control bit 1 routes clock output to its pin
// RULE14 - control bit 0 selects cpu clock undivided or divided by 32
// RULE15 - option byte picks external, resonator range or internal rc
// RULE16 - a selected resonator keeps running during reset
// RULE17 - without multi-oscillator, external clock comes from port b pin 4
// RULE18 - lock flag cleared at reset and restart, until start-up delay
module mcc_clock_ctrl
  import mcc_pkg::*;
#(
  parameter int STARTUP_CYC = (`MCC_STARTUP_NS + `MCC_CLK_NS - 1) / `MCC_CLK_NS
) (
  input  wire logic       clk,               // 20 MHz system clock
  input  wire logic       reset_n,           // async reset, active low
  input  wire logic [3:0] addr,              // register address
  input  wire logic [7:0] wdata,             // write data
  input  wire logic       wr,                // write strobe
  input  wire logic       rd,                // read strobe
  output logic      [7:0] rdata,             // read data, cycle after rd
  input  wire logic [1:0] opt_src,           // option byte clock source
  input  wire logic [2:0] opt_xtal_range,    // option byte resonator range
  input  wire logic       opt_pll_en,        // option bit pll enable
  input  wire logic       opt_pll_x8,        // option bit pll factor 8
  input  wire logic       pll_restart,       // pulse: wake-up from halt
  input  wire logic       readout_prot,      // readout protection setting
  input  wire logic [7:0] nv_rdata,          // nonvolatile data at nv_addr
  output logic     [15:0] nv_addr,           // nonvolatile trim address
  output logic            nv_erase,          // pulse: erase factory trims
  output logic      [7:0] trim_bits,         // trim code to rc oscillator
  output logic            rc_enable,         // internal rc oscillator on
  output logic            xtal_enable,       // resonator oscillator on
  output logic      [2:0] xtal_range,        // resonator range select
  output logic            ext_from_pb4,      // external clock from port b pin 4
  output logic            pll_enable,        // pll running
  output logic            pll_x8,            // pll factor 8 (else 4)
  output logic            osc_gate,          // oscillator clock released
  output logic            osc_sel_pll,       // oscillator clock from pll
  output logic            osc_sel_ext,       // oscillator clock from ext input
  output logic            cpu_div32,         // cpu clock divided by 32
  output logic            cpu_tick,          // cpu clock enable pulse
  output logic            clock_output_enable // clock out function on pin
);

  //--------------------------------------------------------------
  // register file
  //--------------------------------------------------------------
  logic [7:0]  ctrl_r;
  logic [7:0]  trim_r;
  logic [7:0]  ftrim5_r;
  logic [7:0]  ftrim3_r;
  logic        lock_r;
  mcc_pll_e    pll_st_r;
  logic [$clog2(STARTUP_CYC+1)-1:0] su_cnt_r;
  logic [4:0]  div_cnt_r;
  logic        rp_s1_r, rp_s2_r, rp_seen_r;
  logic        rs_s1_r, rs_s2_r, rs_d_r;
  logic [1:0]  ld_r;

  // control register, upper bits forced zero on write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= `MCC_CTRL_RESET; // RULE12
    end else if (wr && addr == `MCC_ADDR_CTRL) begin
      ctrl_r <= wdata & `MCC_CTRL_WMASK; // RULE12 RULE13 RULE14
    end
  end

  // trim register, ff after every reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      trim_r <= `MCC_TRIM_RESET; // RULE1
    end else if (wr && addr == `MCC_ADDR_TRIM) begin
      trim_r <= wdata; // RULE2
    end
  end

  //--------------------------------------------------------------
  // factory trim fetch and erase
  //--------------------------------------------------------------
  // fetch the two factory values from nonvolatile memory after reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ld_r     <= 2'h0;
      nv_addr  <= `MCC_NV_TRIM5;
      ftrim5_r <= `MCC_NV_ERASED;
      ftrim3_r <= `MCC_NV_ERASED;
    end else begin
      if (ld_r != 2'h3) begin
        ld_r <= ld_r + 2'h1;
      end
      if (ld_r == 2'h0) begin
        nv_addr <= `MCC_NV_TRIM3; // RULE4
      end
      if (ld_r == 2'h1) begin
        ftrim5_r <= nv_rdata; // RULE4
      end
      if (ld_r == 2'h2) begin
        ftrim3_r <= nv_rdata; // RULE4
      end
      if (nv_erase) begin
        ftrim5_r <= `MCC_NV_ERASED; // RULE5
        ftrim3_r <= `MCC_NV_ERASED; // RULE5
      end
    end
  end

  // protection pin is asynchronous, synchronise before use
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rp_s1_r   <= 1'b0;
      rp_s2_r   <= 1'b0;
      rp_seen_r <= 1'b0;
      nv_erase  <= 1'b0;
    end else begin
      rp_s1_r   <= readout_prot;
      rp_s2_r   <= rp_s1_r;
      rp_seen_r <= rp_s2_r;
      nv_erase  <= rp_seen_r && !rp_s2_r; // RULE5
    end
  end

  //--------------------------------------------------------------
  // source selection from option byte
  //--------------------------------------------------------------
  // decode the option byte into oscillator enables and clock muxes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rc_enable    <= 1'b0;
      xtal_enable  <= 1'b1; // RULE16
      xtal_range   <= 3'h0;
      ext_from_pb4 <= 1'b0;
      pll_enable   <= 1'b0;
      pll_x8       <= 1'b0;
      osc_sel_pll  <= 1'b0;
      osc_sel_ext  <= 1'b0;
    end else begin
      rc_enable    <= opt_src == MCC_SRC_RC; // RULE15
      xtal_enable  <= opt_src == MCC_SRC_XTAL; // RULE15 RULE16
      xtal_range   <= opt_xtal_range;
      ext_from_pb4 <= opt_src == MCC_SRC_PB4; // RULE17
      pll_enable   <= opt_pll_en; // RULE7
      pll_x8       <= opt_pll_x8; // RULE7
      osc_sel_pll  <= opt_pll_en; // RULE7 RULE8
      osc_sel_ext  <= !opt_pll_en && opt_src != MCC_SRC_RC; // RULE9
    end
  end

  //--------------------------------------------------------------
  // pll start-up and lock
  //--------------------------------------------------------------
  // wake-up pulse comes from the power manager domain
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rs_s1_r <= 1'b0;
      rs_s2_r <= 1'b0;
      rs_d_r  <= 1'b0;
    end else begin
      rs_s1_r <= pll_restart;
      rs_s2_r <= rs_s1_r;
      rs_d_r  <= rs_s2_r;
    end
  end

  // pll state machine: wait out the start-up count before clock and lock
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pll_st_r <= MCC_PLL_OFF;
      su_cnt_r <= '0;
      lock_r   <= 1'b0; // RULE18
      osc_gate <= 1'b0;
    end else if (rs_s2_r && !rs_d_r) begin
      pll_st_r <= MCC_PLL_OFF;
      su_cnt_r <= '0;
      lock_r   <= 1'b0; // RULE18
      osc_gate <= 1'b0; // RULE10
    end else begin
      unique case (pll_st_r)
        MCC_PLL_OFF: begin
          su_cnt_r <= '0;
          if (opt_pll_en) begin
            pll_st_r <= MCC_PLL_WAIT;
          end else begin
            osc_gate <= 1'b1; // RULE8 RULE9
          end
        end
        MCC_PLL_WAIT: begin
          su_cnt_r <= su_cnt_r + 1'b1;
          if (su_cnt_r == ($bits(su_cnt_r))'(STARTUP_CYC - 1)) begin
            pll_st_r <= MCC_PLL_LOCKED;
            lock_r   <= 1'b1; // RULE11
            osc_gate <= 1'b1; // RULE10
          end
        end
        MCC_PLL_LOCKED: begin
          lock_r   <= 1'b1; // RULE11
          osc_gate <= 1'b1;
        end
      endcase
    end
  end

  //--------------------------------------------------------------
  // cpu clock and clock out
  //--------------------------------------------------------------
  // free-running divider gives the slow-mode tick; outputs are registered copies
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt_r           <= 5'h0;
      cpu_tick            <= 1'b0;
      cpu_div32           <= 1'b0;
      clock_output_enable <= 1'b0;
      trim_bits           <= `MCC_TRIM_RESET;
    end else begin
      div_cnt_r           <= div_cnt_r + 5'h1;
      cpu_div32           <= ctrl_r[`MCC_BIT_SLOW]; // RULE14
      cpu_tick            <= osc_gate && (!ctrl_r[`MCC_BIT_SLOW] ||
                                          div_cnt_r == 5'(`MCC_SLOW_DIV - 1)); // RULE14
      clock_output_enable <= ctrl_r[`MCC_BIT_CKOUT]; // RULE13
      trim_bits           <= trim_r; // RULE2
    end
  end

  // read port, data in the cycle after the strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 8'h00;
    end else if (rd) begin
      unique case (addr)
        `MCC_ADDR_CTRL:   rdata <= ctrl_r;
        `MCC_ADDR_TRIM:   rdata <= trim_r;
        `MCC_ADDR_STATUS: rdata <= {7'h00, lock_r};
        `MCC_ADDR_FTRIM5: rdata <= ftrim5_r;
        `MCC_ADDR_FTRIM3: rdata <= ftrim3_r;
        default:          rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  //--------------------------------------------------------------
  // assertions: registers and factory trims
  //--------------------------------------------------------------
  // trim loads ff on reset and reaches the oscillator a cycle later
  a_trim_reset: assert property (@(posedge clk) $rose(reset_n) |-> trim_r == `MCC_TRIM_RESET) // RULE1
    else $error("trim not ff after reset");
  a_trim_follow: assert property (@(posedge clk) disable iff (!reset_n) // RULE2
    trim_bits == $past(trim_r))
    else $error("trim code not passed to oscillator");

  // reserved control bits never read back as one
  a_ctrl_upper_zero: assert property (@(posedge clk) disable iff (!reset_n) // RULE12
    ctrl_r[7:2] == 6'h00)
    else $error("control upper bits set");

  // erase is a single pulse and blanks both factory copies
  a_trim_erase: assert property (@(posedge clk) disable iff (!reset_n) // RULE5
    nv_erase |=> ftrim5_r == `MCC_NV_ERASED && ftrim3_r == `MCC_NV_ERASED)
    else $error("factory trims not erased");
  a_erase_pulse: assert property (@(posedge clk) disable iff (!reset_n) // RULE5
    nv_erase |=> !nv_erase)
    else $error("erase pulse longer than one cycle");

  //--------------------------------------------------------------
  // assertions: source selection
  //--------------------------------------------------------------
  // resonator stays on while reset is held
  a_xtal_reset: assert property (@(posedge clk) !reset_n |=> xtal_enable) // RULE16
    else $error("resonator stopped during reset");
  // decode lags the option byte by one cycle; the first edge after reset still shows reset levels
  a_rc_select: assert property (@(posedge clk) disable iff (!reset_n) // RULE15
    $past(reset_n) |-> rc_enable == ($past(opt_src) == MCC_SRC_RC))
    else $error("rc oscillator enable off option");
  a_pb4_select: assert property (@(posedge clk) disable iff (!reset_n) // RULE17
    $past(reset_n) |-> ext_from_pb4 == ($past(opt_src) == MCC_SRC_PB4))
    else $error("port b pin 4 clock select off option");
  a_pll_factor: assert property (@(posedge clk) disable iff (!reset_n) // RULE7
    $past(reset_n) |-> pll_enable == $past(opt_pll_en) && pll_x8 == $past(opt_pll_x8))
    else $error("pll enable or factor off option");
  a_rc_plain: assert property (@(posedge clk) disable iff (!reset_n) // RULE8
    $past(reset_n) && $past(opt_src) == MCC_SRC_RC && !$past(opt_pll_en) |-> !osc_sel_pll && !osc_sel_ext)
    else $error("rc clock not taken plain");
  a_ext_select: assert property (@(posedge clk) disable iff (!reset_n) // RULE9
    $past(reset_n) && !$past(opt_pll_en) && $past(opt_src) == MCC_SRC_EXT |-> osc_sel_ext && !osc_sel_pll)
    else $error("external clock not selected");

  //--------------------------------------------------------------
  // assertions: pll start-up and lock
  //--------------------------------------------------------------
  // restart edge seen by the synchroniser
  sequence s_restart;
    rs_s2_r && !rs_d_r;
  endsequence

  // pll idle with the option set and no second restart pending
  sequence s_off_ready;
    pll_st_r == MCC_PLL_OFF && opt_pll_en && !(rs_s2_r && !rs_d_r);
  endsequence

  // a restart drops lock, then the pll waits with its clock withheld
  a_lock_clear: assert property (@(posedge clk) disable iff (!reset_n) // RULE18
    s_restart |=> !lock_r)
    else $error("lock not cleared on restart");
  a_restart_wait: assert property (@(posedge clk) disable iff (!reset_n) // RULE10
    s_restart ##1 s_off_ready |=> pll_st_r == MCC_PLL_WAIT && !osc_gate && !lock_r)
    else $error("pll not waiting after restart");
  a_lock_wait: assert property (@(posedge clk) disable iff (!reset_n) // RULE18
    pll_st_r == MCC_PLL_WAIT |-> !lock_r && !osc_gate)
    else $error("lock or clock during start-up");
  // lock only rises at the end of the full start-up count, never ahead of the clock
  a_lock_count: assert property (@(posedge clk) disable iff (!reset_n) // RULE11
    $rose(lock_r) |-> $past(pll_st_r) == MCC_PLL_WAIT && $past(su_cnt_r) == ($bits(su_cnt_r))'(STARTUP_CYC - 1))
    else $error("lock before start-up delay ran out");
  a_lock_gate: assert property (@(posedge clk) disable iff (!reset_n) // RULE10
    lock_r |-> osc_gate)
    else $error("lock without released clock");

  //--------------------------------------------------------------
  // assertions: cpu clock and clock out
  //--------------------------------------------------------------
  // control bits reach their outputs one cycle after the write
  a_clkout_follow: assert property (@(posedge clk) disable iff (!reset_n) // RULE13
    clock_output_enable == $past(ctrl_r[`MCC_BIT_CKOUT]))
    else $error("clock out not following control");
  a_slow_flag: assert property (@(posedge clk) disable iff (!reset_n) // RULE14
    cpu_div32 == $past(ctrl_r[`MCC_BIT_SLOW]))
    else $error("slow mode flag not following control");
  // normal mode ticks with every released clock, slow mode once per divide period
  a_cpu_full: assert property (@(posedge clk) disable iff (!reset_n) // RULE14
    $past(reset_n) && !$past(ctrl_r[`MCC_BIT_SLOW]) |-> cpu_tick == $past(osc_gate))
    else $error("cpu tick missing in normal mode");
  a_slow_tick: assert property (@(posedge clk) disable iff (!reset_n) // RULE14
    cpu_tick && $past(ctrl_r[`MCC_BIT_SLOW]) |-> $past(div_cnt_r) == 5'(`MCC_SLOW_DIV - 1))
    else $error("slow tick off divide");

endmodule

// File: verification/mcc_clock_ctrl_test.sv
`timescale 1ns/1ps
`include "mcc_regs.svh"

module mcc_clock_ctrl_test;
  import mcc_pkg::*;
  localparam int SC = 4; // shortened pll start-up
  logic        clk, reset_n, wr, rd, opt_pll_en, opt_pll_x8, pll_restart, readout_prot;
  logic [3:0]  addr;
  logic [7:0]  wdata, rdata, nv_rdata, trim_bits;
  logic [1:0]  opt_src;
  logic [2:0]  opt_xtal_range, xtal_range;
  logic [15:0] nv_addr;
  logic        nv_erase, rc_enable, xtal_enable, ext_from_pb4, pll_enable, pll_x8, osc_gate;
  logic        osc_sel_pll, osc_sel_ext, cpu_div32, cpu_tick, clock_output_enable;
  int          n_errors, n_tests, cyc, n_erase;

  mcc_clock_ctrl #(.STARTUP_CYC(SC)) dut (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .opt_src(opt_src), .opt_xtal_range(opt_xtal_range),
    .opt_pll_en(opt_pll_en), .opt_pll_x8(opt_pll_x8), .pll_restart(pll_restart),
    .readout_prot(readout_prot), .nv_rdata(nv_rdata), .nv_addr(nv_addr), .nv_erase(nv_erase),
    .trim_bits(trim_bits), .rc_enable(rc_enable), .xtal_enable(xtal_enable), .xtal_range(xtal_range),
    .ext_from_pb4(ext_from_pb4), .pll_enable(pll_enable), .pll_x8(pll_x8), .osc_gate(osc_gate),
    .osc_sel_pll(osc_sel_pll), .osc_sel_ext(osc_sel_ext), .cpu_div32(cpu_div32), .cpu_tick(cpu_tick),
    .clock_output_enable(clock_output_enable));

  // ----------------------------------------
  // clock, nonvolatile store, watchdogs
  // ----------------------------------------
  initial clk = 1'b0;
  always #25 clk = ~clk;
  // nonvolatile store answers one cycle after the address, anything else reads 00
  always @(posedge clk) nv_rdata <= (nv_addr == `MCC_NV_TRIM5) ? 8'h4c : (nv_addr == `MCC_NV_TRIM3) ? 8'h3b : 8'h00;
  // erase pulses and run length
  always @(posedge clk) begin
    n_erase <= n_erase + int'(nv_erase === 1'b1);
    cyc     <= cyc + 1;
    if (cyc == 6000) begin
      n_errors = n_errors + 1;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("errors %0d, comparisons %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // reset with the given options; checks levels held during reset
  task automatic do_reset(input logic [1:0] src, input logic en, input logic x8);
    @(posedge clk);
    opt_src <= src; opt_pll_en <= en; opt_pll_x8 <= x8; reset_n <= 1'b0;
    #1 chk(trim_bits, 8'hff);
    chk(xtal_enable, 1'b1);
    chk(nv_addr, `MCC_NV_TRIM5);
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [7:0] d;
    rd_reg(`MCC_ADDR_TRIM, d); chk(d, `MCC_TRIM_RESET);
    rd_reg(`MCC_ADDR_CTRL, d); chk(d, 8'h00);
    chk({clock_output_enable, cpu_div32}, 2'b00);
    wr_reg(`MCC_ADDR_CTRL, 8'hff);
    wr_reg(`MCC_ADDR_TRIM, 8'h80);
    rd_reg(`MCC_ADDR_TRIM, d); chk(d, 8'h80);
    wr_reg(`MCC_ADDR_TRIM, 8'h5a);
    rd_reg(`MCC_ADDR_CTRL, d); chk(d, 8'h03);
    chk({clock_output_enable, cpu_div32}, 2'b11);
    rd_reg(`MCC_ADDR_TRIM, d); chk(d, 8'h5a);
    chk(trim_bits, 8'h5a);
    rd_reg(4'hf, d); chk(d, 8'h00);
    rd_reg(`MCC_ADDR_FTRIM5, d); chk(d, 8'h4c);
    rd_reg(`MCC_ADDR_FTRIM3, d); chk(d, 8'h3b);
    wr_reg(`MCC_ADDR_CTRL, 8'h02);
    @(posedge clk);
    #1 chk({clock_output_enable, cpu_div32}, 2'b10);
  endtask

  // counts cpu ticks over n cycles
  task automatic t_ticks(input logic slow, input int n);
    int k;
    k = 0;
    wr_reg(`MCC_ADDR_CTRL, {7'h00, slow});
    repeat (4) @(posedge clk);
    repeat (n) begin
      @(posedge clk);
      #1 k = k + int'(cpu_tick === 1'b1);
    end
    chk(16'(k), slow ? 16'(n / `MCC_SLOW_DIV) : 16'(n));
  endtask

  task automatic t_erase();
    logic [7:0] d;
    @(posedge clk) readout_prot <= 1'b1;
    repeat (8) @(posedge clk);
    chk(16'(n_erase), 16'h0);
    readout_prot <= 1'b0;
    repeat (8) @(posedge clk);
    chk(16'(n_erase), 16'h1);
    rd_reg(`MCC_ADDR_FTRIM5, d); chk(d, `MCC_NV_ERASED);
    rd_reg(`MCC_ADDR_FTRIM3, d); chk(d, `MCC_NV_ERASED);
  endtask

  task automatic t_sources();
    for (int s = 0; s < 4; s++) begin
      opt_xtal_range <= 3'(s + 3);
      do_reset(2'(s), 1'b0, 1'b0);
      chk({rc_enable, ext_from_pb4, pll_enable}, {s == 2, s == 3, 1'b0});
      chk({xtal_enable, xtal_range}, {s == 1, 3'(s + 3)});
      if (s != 1) chk(osc_sel_ext, s != 2);
    end
  endtask

  // pll start after restart: gate and lock held off for the start-up delay
  task automatic t_pll(input logic x8);
    logic [7:0] d;
    int         w;
    do_reset(MCC_SRC_RC, 1'b1, x8);
    chk({pll_enable, pll_x8, osc_sel_pll}, {1'b1, x8, 1'b1});
    repeat (2 * SC) @(posedge clk);
    rd_reg(`MCC_ADDR_STATUS, d); chk(d[`MCC_BIT_LOCK], 1'b1);
    @(posedge clk) pll_restart <= 1'b1;
    repeat (3) @(posedge clk);
    pll_restart <= 1'b0;
    #1 chk(osc_gate, 1'b0);
    rd_reg(`MCC_ADDR_STATUS, d); chk(d[`MCC_BIT_LOCK], 1'b0);
    w = 5;
    while (osc_gate !== 1'b1 && w < 40) begin
      @(posedge clk);
      #1 w = w + 1;
    end
    chk(16'(w >= SC + 3 && w <= SC + 8), 16'h1);
    rd_reg(`MCC_ADDR_STATUS, d); chk(d[`MCC_BIT_LOCK], 1'b1);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    n_errors = 0; n_tests = 0; cyc = 0; n_erase = 0;
    reset_n = 1'b0; wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 8'h00;
    opt_src = MCC_SRC_RC; opt_xtal_range = 3'h0; opt_pll_en = 1'b0; opt_pll_x8 = 1'b0;
    pll_restart = 1'b0; readout_prot = 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge clk);
    t_regs();
    t_ticks(1'b0, 64);
    t_ticks(1'b1, 320);
    do_reset(MCC_SRC_RC, 1'b0, 1'b0);
    t_regs();
    t_erase();
    t_sources();
    t_pll(1'b0);
    t_pll(1'b1);
    finish_test();
  end
endmodule
